// ==== logic/can_mode_pkg.sv ====
// Shared constants and types for the CAN operating-mode control block
package can_mode_pkg;

    // One distinct code per mode, identical in request and status fields
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SLEEP = 3'h1,
        MODE_LOOPBACK = 3'h2,
        MODE_LISTEN = 3'h3,
        MODE_CONFIG = 3'h4
    } op_mode_t;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] INTF_OFS = 8'h08;
    localparam logic [7:0] INTE_OFS = 8'h0c;
    localparam logic [7:0] BTA_OFS = 8'h10;
    localparam logic [7:0] BTB_OFS = 8'h14;
    localparam logic [7:0] BTC_OFS = 8'h18;
    localparam logic [7:0] RTS_OFS = 8'h1c;
    localparam logic [7:0] FILTER_OFS = 8'h20;
    localparam logic [7:0] MASK_OFS = 8'h24;
    localparam logic [7:0] ERRCNT_OFS = 8'h28;

    // Field positions
    localparam int MODE_LSB = 0;
    localparam int WAKE_BIT = 0;

    // Reset values
    localparam op_mode_t MODE_RESET = MODE_CONFIG;
    localparam logic [7:0] BT_RESET = 8'h00;
    localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Timing: start-up in oscillator periods, wake filter in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 10;
    localparam int STARTUP_PERIODS = 128;
    localparam int STARTUP_CYCLES = (STARTUP_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_FILTER_NS = 500;
    localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] btA;
        logic [7:0] btB;
        logic [7:0] btC;
        logic [7:0] rtsCtrl;
        logic [31:0] filter;
        logic [31:0] mask;
    } cfg_t;

    typedef struct packed {
        logic txEnable;
        logic ackEnable;
        logic errFrameEnable;
        logic loopback;
        logic ignoreAck;
        logic filterBypass;
        logic errCountEn;
        logic rxDiscard;
    } engine_ctl_t;

    typedef struct packed {
        logic driverEn;
        logic hsRxEn;
        logic lpRxEn;
    } xcvr_ctl_t;

    typedef struct packed {
        op_mode_t modeReq;
        op_mode_t mode;
        logic waking;
        logic [7:0] startCnt;
        logic wakeFlag;
        logic wakeIe;
        cfg_t cfg;
        logic [7:0] tec;
        logic [7:0] rec;
        logic rxPrev;
        logic dPhase;
        logic dWrite;
        logic [7:0] dAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic busTx;
        logic oscEnable;
        logic wakeIrq;
        logic xcvrRx;
        engine_ctl_t eng;
        xcvr_ctl_t xcvr;
    } ctl_state_t;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic out;
    } sync_state_t;

    typedef struct packed {
        logic [7:0] lowCnt;
        logic level;
    } filt_state_t;

endpackage

// ==== logic/pin_sync.sv ====
// Three-stage pin synchroniser that passes a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pinIn,
    output logic pinOut
);
    can_mode_pkg::sync_state_t s_r;
    can_mode_pkg::sync_state_t s_nxt;

    // First stage feeds only the second one
    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = pinIn;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        if (s_r.ff2 == s_r.ff3) begin
            s_nxt.out = s_r.ff3;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= {4{RESET_VAL}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pinOut = s_r.out;
endmodule

// ==== logic/wake_filter.sv ====
// Bus wake-up filter: output goes low only after a sustained dominant level
`timescale 1ns/1ps
module wake_filter (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic busLevel,
    output logic filtLevel
);
    can_mode_pkg::filt_state_t s_r;
    can_mode_pkg::filt_state_t s_nxt;

    // Short dominant glitches restart the count, so noise never wakes the node
    always_comb begin
        s_nxt = s_r;
        if (busLevel) begin
            s_nxt.lowCnt = 8'h00;
            s_nxt.level = 1'b1;
        end else if (s_r.lowCnt == 8'(can_mode_pkg::WAKE_FILTER_CYCLES - 1)) begin
            s_nxt.level = 1'b0;
        end else begin
            s_nxt.lowCnt = s_r.lowCnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= {8'h00, 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign filtLevel = s_r.level;
endmodule

// ==== logic/can_mode_control.sv ====
// Operating-mode control, transceiver mode pins and register slave for the CAN controller
//
// Overview of operation
// - Five modes: configuration, normal, sleep, listen-only, loopback; 3-bit request field.
// - A mode switch waits until no transmission is pending.
// - Mode in force reads back in a 3-bit status field; host confirms there.
// - Standby low: transceiver driver and high-speed receiver active.
// - Standby high: driver, fast receiver off; low-power receiver, filtered delayed output.
// - Configuration mode after reset, and on request from any mode except sleep.
// - Entering configuration clears transmit and receive error counters.
// - Bit timing, request-pin control and filter registers writable only in configuration.
// - Normal mode alone drives the bus, acknowledges and sends error frames.
// - Registers stay readable over the host port while asleep.
// - Fully active until status shows sleep; host polls status.
// - Sleep stops the oscillator; wake on bus activity or host-set wake flag.
// - Wake flag marks a wake attempt; interrupt only when enabled.
// - Asleep, a falling receive edge sets the wake flag.
// - In standby, filtered bus activity drives the receive output low.
// - After wake, a 128 oscillator-period start-up timer runs before receiving.
// - Waking message and start-up traffic discarded; wake ends in listen-only.
// - Listen-only: silent, receives everything ignoring filters, error counters held reset.
// - Loopback: frames looped internally, missing acknowledge ignored.
// - Loopback: nothing to the bus, transmit output held recessive.
// - Loopback: filters and masks still select; all-zero mask accepts all.
`timescale 1ns/1ps
module can_mode_control (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic txPending,
    input wire logic engineTx,
    input wire logic tecInc,
    input wire logic recInc,
    input wire logic transceiverStandbyIn,
    input wire logic canBusIn,
    input wire logic controllerBusRxIn,
    output logic controllerBusTxOut,
    output logic transceiverRxOut,
    output logic oscEnable,
    output logic wakeIrq,
    output can_mode_pkg::engine_ctl_t engineCtl,
    output can_mode_pkg::xcvr_ctl_t xcvrCtl,
    output can_mode_pkg::cfg_t cfgOut,
    output can_mode_pkg::op_mode_t modeOut
);
    can_mode_pkg::ctl_state_t s_r;
    can_mode_pkg::ctl_state_t s_nxt;
    logic addrPhase;
    logic inRange;
    logic rxSync;
    logic busSync;
    logic standbySync;
    logic filtLevel;
    logic rxFall;
    logic hostWake;
    logic wakeEvt;

    function automatic logic validMode(input logic [2:0] code);
        validMode = (code == can_mode_pkg::MODE_NORMAL) || (code == can_mode_pkg::MODE_SLEEP) ||
            (code == can_mode_pkg::MODE_LOOPBACK) || (code == can_mode_pkg::MODE_LISTEN) ||
            (code == can_mode_pkg::MODE_CONFIG);
    endfunction

    // Register read mux; status carries the mode in force
    function automatic logic [31:0] regRead(input can_mode_pkg::ctl_state_t st, input logic [7:0] a,
        input logic pend);
        case (a)
            can_mode_pkg::CTRL_OFS: regRead = {29'h0, st.modeReq};
            can_mode_pkg::STATUS_OFS: regRead = {27'h0, pend, st.waking, st.mode};
            can_mode_pkg::INTF_OFS: regRead = {31'h0, st.wakeFlag};
            can_mode_pkg::INTE_OFS: regRead = {31'h0, st.wakeIe};
            can_mode_pkg::BTA_OFS: regRead = {24'h0, st.cfg.btA};
            can_mode_pkg::BTB_OFS: regRead = {24'h0, st.cfg.btB};
            can_mode_pkg::BTC_OFS: regRead = {24'h0, st.cfg.btC};
            can_mode_pkg::RTS_OFS: regRead = {24'h0, st.cfg.rtsCtrl};
            can_mode_pkg::FILTER_OFS: regRead = st.cfg.filter;
            can_mode_pkg::MASK_OFS: regRead = st.cfg.mask;
            can_mode_pkg::ERRCNT_OFS: regRead = {16'h0, st.rec, st.tec};
            default: regRead = 32'h0;
        endcase
    endfunction

    // Pins from outside the clock domain
    pin_sync #(.RESET_VAL(1'b1)) rxSyncInst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(controllerBusRxIn),
        .pinOut(rxSync)
    );

    pin_sync #(.RESET_VAL(1'b1)) busSyncInst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(canBusIn),
        .pinOut(busSync)
    );

    pin_sync #(.RESET_VAL(1'b1)) standbySyncInst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(transceiverStandbyIn),
        .pinOut(standbySync)
    );

    wake_filter wakeFilterInst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .busLevel(busSync),
        .filtLevel(filtLevel)
    );

    // Address phase is taken only when the bus is ready; upper address bits must be zero
    assign addrPhase = hsel && htrans[1] && hready;
    assign inRange = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);

    // Next-state logic for the whole block
    always_comb begin
        s_nxt = s_r;
        hostWake = 1'b0;
        rxFall = s_r.rxPrev && !rxSync;
        s_nxt.rxPrev = rxSync;

        // Data-phase writes; writes stay accepted in sleep so the host can set the wake flag
        if (s_r.dPhase && s_r.dWrite) begin
            case (s_r.dAddr)
                can_mode_pkg::CTRL_OFS: begin
                    if (validMode(hwdata[can_mode_pkg::MODE_LSB +: 3])) begin
                        s_nxt.modeReq = can_mode_pkg::op_mode_t'(hwdata[can_mode_pkg::MODE_LSB +: 3]);
                    end
                end
                can_mode_pkg::INTF_OFS: begin
                    s_nxt.wakeFlag = hwdata[can_mode_pkg::WAKE_BIT];
                    hostWake = hwdata[can_mode_pkg::WAKE_BIT] && !s_r.wakeFlag;
                end
                can_mode_pkg::INTE_OFS: s_nxt.wakeIe = hwdata[can_mode_pkg::WAKE_BIT];
                default: ;
            endcase
            if (s_r.mode == can_mode_pkg::MODE_CONFIG) begin
                case (s_r.dAddr)
                    can_mode_pkg::BTA_OFS: s_nxt.cfg.btA = hwdata[7:0];
                    can_mode_pkg::BTB_OFS: s_nxt.cfg.btB = hwdata[7:0];
                    can_mode_pkg::BTC_OFS: s_nxt.cfg.btC = hwdata[7:0];
                    can_mode_pkg::RTS_OFS: s_nxt.cfg.rtsCtrl = hwdata[7:0];
                    can_mode_pkg::FILTER_OFS: s_nxt.cfg.filter = hwdata;
                    can_mode_pkg::MASK_OFS: s_nxt.cfg.mask = hwdata;
                    default: ;
                endcase
            end
        end

        // falling receive edge or host-set wake flag while asleep and not yet waking; the set wins over a clearing write
        wakeEvt = (s_r.mode == can_mode_pkg::MODE_SLEEP) && !s_r.waking && (rxFall || hostWake);
        if (wakeEvt) begin
            s_nxt.wakeFlag = 1'b1;
        end

        // Mode sequencer
        case (s_r.mode)
            can_mode_pkg::MODE_SLEEP: begin
                if (!s_r.waking) begin
                    if (wakeEvt) begin
                        s_nxt.waking = 1'b1;
                        s_nxt.startCnt = 8'h00;
                    end
                end else if (s_r.startCnt == 8'(can_mode_pkg::STARTUP_CYCLES - 1)) begin
                    s_nxt.mode = can_mode_pkg::MODE_LISTEN;
                    s_nxt.waking = 1'b0;
                    // A stale sleep request would put the node straight back to sleep
                    if (s_nxt.modeReq == can_mode_pkg::MODE_SLEEP) begin
                        s_nxt.modeReq = can_mode_pkg::MODE_LISTEN;
                    end
                end else begin
                    s_nxt.startCnt = s_r.startCnt + 8'h01;
                end
            end
            can_mode_pkg::MODE_NORMAL, can_mode_pkg::MODE_LISTEN, can_mode_pkg::MODE_LOOPBACK,
            can_mode_pkg::MODE_CONFIG: begin
                // any mode but sleep may return to configuration
                // sleep takes effect only here, status follows
                if ((s_r.modeReq != s_r.mode) && !txPending) begin
                    s_nxt.mode = s_r.modeReq;
                end
            end
            default: s_nxt.mode = can_mode_pkg::MODE_CONFIG;
        endcase

        if ((s_nxt.mode == can_mode_pkg::MODE_CONFIG) || (s_nxt.mode == can_mode_pkg::MODE_LISTEN)) begin
            s_nxt.tec = 8'h00;
            s_nxt.rec = 8'h00;
        end else if (s_r.eng.errCountEn) begin
            if (tecInc && (s_r.tec != 8'hff)) begin
                s_nxt.tec = s_r.tec + 8'h01;
            end
            if (recInc && (s_r.rec != 8'hff)) begin
                s_nxt.rec = s_r.rec + 8'h01;
            end
        end

        // only normal mode drives, acknowledges and flags errors
        s_nxt.eng.txEnable = (s_nxt.mode == can_mode_pkg::MODE_NORMAL);
        s_nxt.eng.ackEnable = (s_nxt.mode == can_mode_pkg::MODE_NORMAL);
        s_nxt.eng.errFrameEnable = (s_nxt.mode == can_mode_pkg::MODE_NORMAL);
        s_nxt.eng.loopback = (s_nxt.mode == can_mode_pkg::MODE_LOOPBACK);
        s_nxt.eng.ignoreAck = (s_nxt.mode == can_mode_pkg::MODE_LOOPBACK);
        // loopback keeps filters; only listen-only bypasses them
        s_nxt.eng.filterBypass = (s_nxt.mode == can_mode_pkg::MODE_LISTEN);
        s_nxt.eng.errCountEn = (s_nxt.mode == can_mode_pkg::MODE_NORMAL) ||
            (s_nxt.mode == can_mode_pkg::MODE_LOOPBACK);
        // traffic during sleep and start-up is dropped
        s_nxt.eng.rxDiscard = (s_nxt.mode == can_mode_pkg::MODE_SLEEP);

        s_nxt.busTx = (s_nxt.mode == can_mode_pkg::MODE_NORMAL) ? engineTx : 1'b1;
        s_nxt.oscEnable = !((s_nxt.mode == can_mode_pkg::MODE_SLEEP) && !s_nxt.waking);
        s_nxt.wakeIrq = s_nxt.wakeFlag && s_nxt.wakeIe;

        // standby high: low-power path through the wake filter
        s_nxt.xcvr.driverEn = !standbySync;
        s_nxt.xcvr.hsRxEn = !standbySync;
        s_nxt.xcvr.lpRxEn = standbySync;
        s_nxt.xcvrRx = standbySync ? filtLevel : busSync;

        // Bus slave: zero wait states, always OKAY
        s_nxt.dPhase = addrPhase;
        s_nxt.dWrite = addrPhase && hwrite && inRange;
        s_nxt.dAddr = haddr[7:0];
        s_nxt.hreadyout = 1'b1;
        s_nxt.hresp = 1'b0;
        // reads served in every mode, sleep included
        // read data taken after this cycle's writes
        if (addrPhase && !hwrite && inRange) begin
            s_nxt.hrdata = regRead(s_nxt, haddr[7:0], txPending);
        end else begin
            s_nxt.hrdata = 32'h0;
        end
    end

    // State register; configuration mode after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.modeReq <= can_mode_pkg::MODE_RESET;
            s_r.mode <= can_mode_pkg::MODE_RESET;
            s_r.cfg.btA <= can_mode_pkg::BT_RESET;
            s_r.cfg.btB <= can_mode_pkg::BT_RESET;
            s_r.cfg.btC <= can_mode_pkg::BT_RESET;
            s_r.cfg.filter <= can_mode_pkg::FILTER_RESET;
            s_r.cfg.mask <= can_mode_pkg::MASK_RESET;
            s_r.rxPrev <= 1'b1;
            s_r.hreadyout <= 1'b1;
            s_r.busTx <= 1'b1;
            s_r.oscEnable <= 1'b1;
            s_r.xcvrRx <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign hreadyout = s_r.hreadyout;
    assign hresp = s_r.hresp;
    assign hrdata = s_r.hrdata;
    assign controllerBusTxOut = s_r.busTx;
    assign transceiverRxOut = s_r.xcvrRx;
    assign oscEnable = s_r.oscEnable;
    assign wakeIrq = s_r.wakeIrq;
    assign engineCtl = s_r.eng;
    assign xcvrCtl = s_r.xcvr;
    assign cfgOut = s_r.cfg;
    assign modeOut = s_r.mode;

    // Wake start as seen in state
    sequence s_wakeStart;
        (s_r.mode == can_mode_pkg::MODE_SLEEP) && $rose(s_r.waking);
    endsequence

    property p_silentOutsideNormal;
        @(posedge ref_clk) disable iff (!resetn)
        (s_r.mode != can_mode_pkg::MODE_NORMAL) |-> controllerBusTxOut && !engineCtl.ackEnable;
    endproperty
    a_silentOutsideNormal: assert property (p_silentOutsideNormal) else $error("bus driven outside normal");

    property p_configCounters;
        @(posedge ref_clk) disable iff (!resetn)
        $changed(s_r.mode) && (s_r.mode == can_mode_pkg::MODE_CONFIG) |-> (s_r.tec == 8'h00) && (s_r.rec == 8'h00);
    endproperty
    a_configCounters: assert property (p_configCounters) else $error("counters not cleared");

    property p_listenSilent;
        @(posedge ref_clk) disable iff (!resetn)
        (s_r.mode == can_mode_pkg::MODE_LISTEN) |-> !engineCtl.txEnable && engineCtl.filterBypass && (s_r.tec == 8'h00);
    endproperty
    a_listenSilent: assert property (p_listenSilent) else $error("listen-only not silent");

    property p_deferred;
        @(posedge ref_clk) disable iff (!resetn)
        txPending && (s_r.mode != can_mode_pkg::MODE_SLEEP) |=> $stable(s_r.mode);
    endproperty
    a_deferred: assert property (p_deferred) else $error("mode changed while pending");

    property p_startup;
        @(posedge ref_clk) disable iff (!resetn)
        s_wakeStart |-> ##127 (s_r.mode == can_mode_pkg::MODE_SLEEP) ##1 (s_r.mode == can_mode_pkg::MODE_LISTEN);
    endproperty
    a_startup: assert property (p_startup) else $error("start-up timer length wrong");

    property p_wakeDiscard;
        @(posedge ref_clk) disable iff (!resetn)
        s_wakeStart |-> (engineCtl.rxDiscard && oscEnable)[*8];
    endproperty
    a_wakeDiscard: assert property (p_wakeDiscard) else $error("traffic not discarded on wake");

    property p_wakeEdge;
        @(posedge ref_clk) disable iff (!resetn)
        (s_r.mode == can_mode_pkg::MODE_SLEEP) && !s_r.waking && s_r.rxPrev && !rxSync |=> s_r.wakeFlag && s_r.waking;
    endproperty
    a_wakeEdge: assert property (p_wakeEdge) else $error("falling edge did not wake");

    property p_wakeIrq;
        @(posedge ref_clk) disable iff (!resetn)
        wakeIrq == (s_r.wakeFlag && s_r.wakeIe);
    endproperty
    a_wakeIrq: assert property (p_wakeIrq) else $error("wake interrupt gating wrong");

    property p_protect;
        @(posedge ref_clk) disable iff (!resetn)
        s_r.dPhase && (s_r.mode != can_mode_pkg::MODE_CONFIG) |=> $stable(s_r.cfg);
    endproperty
    a_protect: assert property (p_protect) else $error("protected register written");

    property p_oscStop;
        @(posedge ref_clk) disable iff (!resetn)
        (s_r.mode == can_mode_pkg::MODE_SLEEP) && !s_r.waking |-> !oscEnable;
    endproperty
    a_oscStop: assert property (p_oscStop) else $error("oscillator running in sleep");

    property p_standby;
        @(posedge ref_clk) disable iff (!resetn)
        standbySync |=> xcvrCtl.lpRxEn && !xcvrCtl.driverEn && !xcvrCtl.hsRxEn;
    endproperty
    a_standby: assert property (p_standby) else $error("standby path not selected");

    property p_statusRead;
        @(posedge ref_clk) disable iff (!resetn)
        addrPhase && !hwrite && (haddr == 32'(can_mode_pkg::STATUS_OFS)) |=> (hrdata[2:0] == s_r.mode);
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status does not show mode");
endmodule

// ==== test/can_bus_node.sv ====
// Far-side bus node: drives a dominant burst timed by the link clock
`timescale 1ns/1ps
module can_bus_node (
    input wire logic linkClk,
    input wire logic go,
    output logic busLevel
);
    logic [3:0] left = 4'h0;
    // Twelve dominant bits, long enough to pass the wake filter
    always @(posedge linkClk) begin
        if (left != 4'h0) begin
            left <= left - 4'h1;
        end else if (go) begin
            left <= 4'hc;
        end
    end
    // A released bus returns to recessive through its termination
    assign busLevel = (left == 4'h0);
endmodule

// ==== test/can_mode_control_tb_top.sv ====
// Self-checking bench for the CAN operating-mode control block
`timescale 1ns/1ps
module can_mode_control_tb_top;
    logic ref_clk, linkClk, resetn, hsel, hwrite, txPending, engineTx, tecInc, recInc, transceiver_standby_input, go, busLvl;
    logic hreadyout, hresp, txOut, rxOut, oscEnable, wakeIrq;
    logic [31:0] haddr, hwdata, hrdata, r, v, cnt;
    logic [31:0] seed = 32'h28fa;
    logic [11:0] modeList = 12'h423;
    logic [1:0] htrans;
    can_mode_pkg::xcvr_ctl_t xc;
    can_mode_pkg::engine_ctl_t eng;
    can_mode_pkg::cfg_t cfg;
    can_mode_pkg::op_mode_t modeOut, m;
    int numErrors = 0, checked = 0, cyc = 0;
    can_mode_control dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .txPending(txPending), .engineTx(engineTx), .tecInc(tecInc),
        .recInc(recInc), .transceiverStandbyIn(transceiver_standby_input), .canBusIn(busLvl), .controllerBusRxIn(rxOut),
        .controllerBusTxOut(txOut), .transceiverRxOut(rxOut), .oscEnable(oscEnable), .wakeIrq(wakeIrq),
        .engineCtl(eng), .xcvrCtl(xc), .cfgOut(cfg), .modeOut(modeOut));
    can_bus_node node (.linkClk(linkClk), .go(go), .busLevel(busLvl));
    // Core clock and an unrelated 80 ns link clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        linkClk = 0;
        #13 forever #40 linkClk = ~linkClk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Only normal mode may put the engine's bit on the wire
    function automatic logic expTx(input can_mode_pkg::op_mode_t md, input logic b);
        return (md == can_mode_pkg::MODE_NORMAL) ? b : 1'b1;
    endfunction
    // Engine enables per mode: normal drives, loopback loops, listen-only skips filters
    function automatic can_mode_pkg::engine_ctl_t expEng(input can_mode_pkg::op_mode_t md);
        logic n, l;
        n = (md == can_mode_pkg::MODE_NORMAL);
        l = (md == can_mode_pkg::MODE_LOOPBACK);
        return {n, n, n, l, l, (md == can_mode_pkg::MODE_LISTEN), n || l, (md == can_mode_pkg::MODE_SLEEP)};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One AHB single transfer; no wait count assumed, the timeout cuts hangs
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        cmp(r, e);
    endtask
    // Mode lands one edge after the write's data phase
    task automatic setm(input can_mode_pkg::op_mode_t md);
        ahb(1'b1, can_mode_pkg::CTRL_OFS, {29'h0, md});
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic print_verdict();
        if (numErrors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            numErrors++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        {resetn, hsel, hwrite, txPending, tecInc, recInc, transceiver_standby_input, go, haddr, hwdata, htrans} = '0;
        engineTx = 1'b1;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(can_mode_pkg::STATUS_OFS, 32'h4);
        v = rnd();
        ahb(1'b1, can_mode_pkg::BTA_OFS, v);
        rd(can_mode_pkg::BTA_OFS, {24'h0, v[7:0]});
        txPending <= 1'b1;
        setm(can_mode_pkg::MODE_NORMAL);
        rd(can_mode_pkg::STATUS_OFS, 32'h14);
        txPending <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(can_mode_pkg::STATUS_OFS, 32'h0);
        ahb(1'b1, can_mode_pkg::BTA_OFS, ~v);
        rd(can_mode_pkg::BTA_OFS, {24'h0, v[7:0]});
        cmp({24'h0, cfg.btA}, {24'h0, v[7:0]});
        // Walk every mode but sleep; configuration follows counting modes so its clear is seen
        cnt = 0;
        for (int k = 3; k >= 0; k--) begin
            m = can_mode_pkg::op_mode_t'(modeList[3 * k +: 3]);
            setm(m);
            cmp({29'h0, modeOut}, {29'h0, m});
            cmp({24'h0, eng}, {24'h0, expEng(m)});
            rd(can_mode_pkg::STATUS_OFS, {29'h0, m});
            {tecInc, recInc} <= 2'b11;
            repeat (4) begin
                @(posedge ref_clk);
                {tecInc, recInc} <= 2'b00;
                engineTx <= ^rnd();
                repeat (2) @(posedge ref_clk);
                cmp({31'h0, txOut}, {31'h0, expTx(m, engineTx)});
            end
            cnt = (m == can_mode_pkg::MODE_CONFIG || m == can_mode_pkg::MODE_LISTEN) ? 32'h0 : cnt + 1;
            rd(can_mode_pkg::ERRCNT_OFS, cnt * 32'h101);
        end
        // Sleep with the transceiver in standby, then a bus wake
        ahb(1'b1, can_mode_pkg::INTE_OFS, 32'h1);
        setm(can_mode_pkg::MODE_SLEEP);
        rd(can_mode_pkg::STATUS_OFS, 32'h1);
        cmp({31'h0, oscEnable}, 32'h0);
        cmp({24'h0, eng}, {24'h0, expEng(can_mode_pkg::MODE_SLEEP)});
        rd(can_mode_pkg::BTA_OFS, {24'h0, v[7:0]});
        transceiver_standby_input <= 1'b1;
        repeat (8) @(posedge ref_clk);
        cmp({29'h0, xc}, 32'h1);
        go <= 1'b1;
        wait (rxOut === 1'b0);
        go <= 1'b0;
        wait (oscEnable === 1'b1);
        repeat (64) @(posedge ref_clk);
        rd(can_mode_pkg::STATUS_OFS, 32'h9);
        repeat (70) @(posedge ref_clk);
        rd(can_mode_pkg::STATUS_OFS, 32'h3);
        rd(can_mode_pkg::INTF_OFS, 32'h1);
        cmp({31'h0, wakeIrq}, 32'h1);
        transceiver_standby_input <= 1'b0;
        ahb(1'b1, can_mode_pkg::INTF_OFS, 32'h0);
        setm(can_mode_pkg::MODE_NORMAL);
        cmp({31'h0, wakeIrq}, 32'h0);
        cmp({29'h0, xc}, 32'h6);
        // Second sleep, woken by the host setting the flag
        setm(can_mode_pkg::MODE_SLEEP);
        ahb(1'b1, can_mode_pkg::INTF_OFS, 32'h1);
        repeat (130) @(posedge ref_clk);
        rd(can_mode_pkg::STATUS_OFS, 32'h3);
        cmp({31'h0, wakeIrq}, 32'h1);
        print_verdict();
    end
endmodule
